// File: core/rxcfg_pkg.sv
package rxcfg_pkg;
   // internal address map, 10-bit word addresses
   localparam logic [9:0] ADDR_COEF_BASE = 10'h000;
   localparam logic [9:0] ADDR_SAMPLE_BASE = 10'h100;
   localparam logic [9:0] ADDR_MODE = 10'h300;
   localparam logic [9:0] ADDR_OSC = 10'h301;
   localparam logic [9:0] ADDR_SYNC_MASK = 10'h302;
   localparam logic [9:0] ADDR_TUNING = 10'h303;
   localparam logic [9:0] ADDR_PHASE = 10'h304;
   localparam logic [9:0] ADDR_IN_SCALE = 10'h305;
   localparam logic [9:0] ADDR_S2_DEC = 10'h306;
   localparam logic [9:0] ADDR_S5_SCALE = 10'h307;
   localparam logic [9:0] ADDR_S5_DEC = 10'h308;
   localparam logic [9:0] ADDR_OUT_CTRL = 10'h309;
   localparam logic [9:0] ADDR_FIR_DEC = 10'h30a;
   localparam logic [9:0] ADDR_COEF_BASE_REG = 10'h30b;
   localparam logic [9:0] ADDR_TAPS = 10'h30c;
   localparam logic [9:0] ADDR_RSVD = 10'h30d;
   // address region select: bits 9:8
   localparam logic [1:0] REGION_COEF = 2'h0;
   localparam logic [1:0] REGION_SAMPLE = 2'h1;
   localparam logic [1:0] REGION_RSVD = 2'h2;
   localparam logic [1:0] REGION_CTRL = 2'h3;
   // widths
   localparam int COEF_W = 20;
   localparam int SAMPLE_W = 36;
   localparam int HALF_W = 18;
   localparam int DATA_W = 36;
   // field masks of the narrow registers
   localparam logic [7:0] MODE_MASK = 8'h0f;
   localparam logic [7:0] OSC_MASK = 8'h07;
   localparam logic [7:0] IN_SCALE_MASK = 8'hf7;
   localparam logic [7:0] S5_SCALE_MASK = 8'h1f;
   localparam logic [7:0] OUT_CTRL_MASK = 8'h0f;
   localparam logic [7:0] MODE_RESET = 8'h01;
   // bit positions
   localparam int MODE_SOFT_RST_BIT = 0;
   localparam int MODE_DIV_BIT = 1;
   localparam int MODE_CPLX_BIT = 2;
   localparam int MODE_MASTER_BIT = 3;
   localparam int OSC_BYPASS_BIT = 0;
   localparam int OSC_PDITH_BIT = 1;
   localparam int OSC_ADITH_BIT = 2;
   localparam int EXP_DIR_BIT = 4;
   localparam int UNIQUE_B_BIT = 3;
   // low bit of each multi-bit field
   localparam int REGION_LSB = 8;
   localparam int S2_SHIFT_LSB = 0;
   localparam int EXP_GAIN_LSB = 5;
   localparam int S5_SHIFT_LSB = 0;
   localparam int OUT_SCALE_LSB = 0;
   // field limits and defaults
   localparam logic [2:0] S2_SHIFT_MAX = 3'h6;
   localparam logic [4:0] S5_SHIFT_MAX = 5'h14;
   localparam logic [2:0] OUT_SCALE_ZERO = 3'h4;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // decoded input modes
   typedef enum logic [1:0] {
      RXCFG_REAL_SINGLE,
      RXCFG_REAL_DIVERSITY,
      RXCFG_COMPLEX_SINGLE,
      RXCFG_HELD_RESET
   } rxcfg_mode_e;
endpackage

// File: core/rxcfg_regbank.sv
`timescale 1ns/1ps
module rxcfg_regbank #(
   parameter int COEF_DEPTH = 256,
   parameter int SAMPLE_DEPTH = 256
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [9:0] busAddr,
   input wire logic [35:0] busWrData,
   input wire logic busWrStb,
   input wire logic busRdStb,
   output logic [35:0] busRdData,
   // datapath view of the configuration
   output logic [1:0] inputMode,
   output logic softResetHeld,
   output logic syncMaster,
   output logic oscBypass,
   output logic phaseDitherEn,
   output logic ampDitherEn,
   output logic [31:0] syncMask,
   output logic [31:0] tuningWord,
   output logic [15:0] phaseWord,
   output logic [2:0] stage2AttenuationShift,
   output logic exponentDirection,
   output logic [2:0] exponentGainOffset,
   output logic [7:0] stage2DecimationM1,
   output logic [4:0] stage5AttenuationShift,
   output logic [7:0] stage5DecimationM1,
   output logic [2:0] outputScaleSelect,
   output logic uniqueCoefB,
   output logic [7:0] firDecimationM1,
   output logic [7:0] coefficientBase,
   output logic [7:0] tapCount,
   output logic ncoPhaseSyncPulse,
   // sync pin enables, low while driving
   output logic syncCicOe_n,
   output logic syncFirOe_n,
   // FIR engine access to memories
   input wire logic [7:0] firCoefAddr,
   output logic [19:0] firCoefData,
   input wire logic [7:0] firSampleAddr,
   input wire logic firSampleWe,
   input wire logic [35:0] firSampleWrData,
   output logic [35:0] firSampleRdData
);

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] osc;
      logic [31:0] syncMask;
      logic [31:0] tuning;
      logic [15:0] phase;
      logic [7:0] inScale;
      logic [7:0] s2Dec;
      logic [7:0] s5Scale;
      logic [7:0] s5Dec;
      logic [7:0] outCtrl;
      logic [7:0] firDec;
      logic [7:0] coefBase;
      logic [7:0] taps;
      logic [35:0] rdData;
      logic syncPulse;
      logic rdMem;
      logic rdCoef;
   } rxcfg_state_s;

   rxcfg_state_s state_reg;
   rxcfg_state_s state_next;

   // memories hold no reset, contents persist across reset
   logic [19:0] coefMem [COEF_DEPTH];
   logic [35:0] sampleMem [SAMPLE_DEPTH];
   logic [19:0] coefRd;
   logic [35:0] sampleRd;
   logic [1:0] region;
   logic [7:0] word;
   logic [7:0] wrByte;

   assign region = busAddr[rxcfg_pkg::REGION_LSB +: 2];
   assign word = busAddr[7:0];
   assign wrByte = busWrData[7:0];

   // host writes win over FIR engine writes to the sample memory
   always_ff @(posedge ref_clk) begin
      if (busWrStb && region == rxcfg_pkg::REGION_COEF) begin
         coefMem[word] <= busWrData[19:0];
      end
      if (busWrStb && region == rxcfg_pkg::REGION_SAMPLE) begin
         sampleMem[word] <= busWrData;
      end else if (firSampleWe) begin
         sampleMem[firSampleAddr] <= firSampleWrData;
      end
      coefRd <= coefMem[word];
      sampleRd <= sampleMem[word];
      firCoefData <= coefMem[firCoefAddr];
      firSampleRdData <= sampleMem[firSampleAddr];
   end

   // register writes and read mux
   always_comb begin
      state_next = state_reg;
      state_next.syncPulse = 1'b0;
      state_next.rdData = '0;
      if (busWrStb && region == rxcfg_pkg::REGION_CTRL) begin
         case (busAddr)
            rxcfg_pkg::ADDR_MODE:
               state_next.mode = wrByte & rxcfg_pkg::MODE_MASK;
            rxcfg_pkg::ADDR_OSC:
               state_next.osc = wrByte & rxcfg_pkg::OSC_MASK;
            rxcfg_pkg::ADDR_SYNC_MASK:
               state_next.syncMask = busWrData[31:0];
            rxcfg_pkg::ADDR_TUNING:
               state_next.tuning = busWrData[31:0];
            rxcfg_pkg::ADDR_PHASE:
               state_next.phase = busWrData[15:0];
            rxcfg_pkg::ADDR_IN_SCALE:
               state_next.inScale = wrByte & rxcfg_pkg::IN_SCALE_MASK;
            rxcfg_pkg::ADDR_S2_DEC:
               state_next.s2Dec = wrByte;
            rxcfg_pkg::ADDR_S5_SCALE:
               state_next.s5Scale = wrByte & rxcfg_pkg::S5_SCALE_MASK;
            rxcfg_pkg::ADDR_S5_DEC:
               state_next.s5Dec = wrByte;
            rxcfg_pkg::ADDR_OUT_CTRL:
               state_next.outCtrl = wrByte & rxcfg_pkg::OUT_CTRL_MASK;
            rxcfg_pkg::ADDR_FIR_DEC:
               state_next.firDec = wrByte;
            rxcfg_pkg::ADDR_COEF_BASE_REG:
               state_next.coefBase = wrByte;
            rxcfg_pkg::ADDR_TAPS:
               state_next.taps = wrByte;
            default: ;
         endcase
      end
      if (busRdStb) begin
         case (busAddr)
            rxcfg_pkg::ADDR_MODE:
               state_next.rdData = {28'h0, state_reg.mode};
            rxcfg_pkg::ADDR_OSC:
               state_next.rdData = {28'h0, state_reg.osc};
            rxcfg_pkg::ADDR_SYNC_MASK:
               state_next.rdData = {4'h0, state_reg.syncMask};
            rxcfg_pkg::ADDR_TUNING: begin
               state_next.rdData = {4'h0, state_reg.tuning};
               // reading tuning word as master resyncs the oscillator
               state_next.syncPulse =
                  state_reg.mode[rxcfg_pkg::MODE_MASTER_BIT];
            end
            rxcfg_pkg::ADDR_PHASE:
               state_next.rdData = {20'h0, state_reg.phase};
            rxcfg_pkg::ADDR_IN_SCALE:
               state_next.rdData = {28'h0, state_reg.inScale};
            rxcfg_pkg::ADDR_S2_DEC:
               state_next.rdData = {28'h0, state_reg.s2Dec};
            rxcfg_pkg::ADDR_S5_SCALE:
               state_next.rdData = {28'h0, state_reg.s5Scale};
            rxcfg_pkg::ADDR_S5_DEC:
               state_next.rdData = {28'h0, state_reg.s5Dec};
            rxcfg_pkg::ADDR_OUT_CTRL:
               state_next.rdData = {28'h0, state_reg.outCtrl};
            rxcfg_pkg::ADDR_FIR_DEC:
               state_next.rdData = {28'h0, state_reg.firDec};
            rxcfg_pkg::ADDR_COEF_BASE_REG:
               state_next.rdData = {28'h0, state_reg.coefBase};
            rxcfg_pkg::ADDR_TAPS: state_next.rdData = {28'h0, state_reg.taps};
            default: state_next.rdData = '0;
         endcase
      end
      // note a memory read so the array output is muxed next cycle
      state_next.rdMem = busRdStb && (region == rxcfg_pkg::REGION_COEF
         || region == rxcfg_pkg::REGION_SAMPLE);
      state_next.rdCoef = region == rxcfg_pkg::REGION_COEF;
      if (rst) begin
         state_next = '0;
         state_next.mode = rxcfg_pkg::MODE_RESET;
      end
   end

   // register the whole state on every rising edge
   always_ff @(posedge ref_clk) begin
      state_reg <= state_next;
   end

   // read data, memory words or register word
   always_comb begin
      if (state_reg.rdMem && state_reg.rdCoef) begin
         busRdData = {16'h0, coefRd};
      end else if (state_reg.rdMem) begin
         busRdData = sampleRd;
      end else begin
         busRdData = state_reg.rdData;
      end
   end

   // mode decode
   always_comb begin
      if (state_reg.mode[rxcfg_pkg::MODE_SOFT_RST_BIT]) begin
         inputMode = rxcfg_pkg::RXCFG_HELD_RESET;
      end else if (state_reg.mode[rxcfg_pkg::MODE_CPLX_BIT]) begin
         inputMode = rxcfg_pkg::RXCFG_COMPLEX_SINGLE;
      end else if (state_reg.mode[rxcfg_pkg::MODE_DIV_BIT]) begin
         inputMode = rxcfg_pkg::RXCFG_REAL_DIVERSITY;
      end else begin
         inputMode = rxcfg_pkg::RXCFG_REAL_SINGLE;
      end
   end

   // configuration fields to the datapath
   assign softResetHeld = state_reg.mode[rxcfg_pkg::MODE_SOFT_RST_BIT];
   assign syncMaster = state_reg.mode[rxcfg_pkg::MODE_MASTER_BIT];
   assign syncCicOe_n = !syncMaster;
   assign syncFirOe_n = !syncMaster;
   assign oscBypass = state_reg.osc[rxcfg_pkg::OSC_BYPASS_BIT];
   assign phaseDitherEn = state_reg.osc[rxcfg_pkg::OSC_PDITH_BIT];
   assign ampDitherEn = state_reg.osc[rxcfg_pkg::OSC_ADITH_BIT];
   assign syncMask = state_reg.syncMask;
   assign tuningWord = state_reg.tuning;
   assign phaseWord = state_reg.phase;
   assign stage2AttenuationShift =
      state_reg.inScale[rxcfg_pkg::S2_SHIFT_LSB +: 3];
   assign exponentDirection =
      state_reg.inScale[rxcfg_pkg::EXP_DIR_BIT];
   assign exponentGainOffset =
      state_reg.inScale[rxcfg_pkg::EXP_GAIN_LSB +: 3];
   assign stage2DecimationM1 = state_reg.s2Dec;
   assign stage5AttenuationShift =
      state_reg.s5Scale[rxcfg_pkg::S5_SHIFT_LSB +: 5];
   assign stage5DecimationM1 = state_reg.s5Dec;
   assign outputScaleSelect =
      state_reg.outCtrl[rxcfg_pkg::OUT_SCALE_LSB +: 3];
   assign uniqueCoefB = state_reg.outCtrl[rxcfg_pkg::UNIQUE_B_BIT];
   assign firDecimationM1 = state_reg.firDec;
   assign coefficientBase = state_reg.coefBase;
   assign tapCount = state_reg.taps;
   assign ncoPhaseSyncPulse = state_reg.syncPulse;

   property p_reset_mode;
      @(posedge ref_clk) rst |=> softResetHeld && !syncMaster;
   endproperty
   a_reset_mode: assert property (p_reset_mode)
      else $error("mode not soft reset slave after reset");

   property p_slave_after_reset;
      @(posedge ref_clk) rst |=> syncCicOe_n && syncFirOe_n;
   endproperty
   a_slave_after_reset: assert property (p_slave_after_reset)
      else $error("sync pins driven after reset");

   property p_sync_pulse;
      @(posedge ref_clk) disable iff (rst)
      busRdStb && busAddr == rxcfg_pkg::ADDR_TUNING
      |=> ncoPhaseSyncPulse == $past(syncMaster);
   endproperty
   a_sync_pulse: assert property (p_sync_pulse)
      else $error("tuning read sync pulse wrong");

   property p_pulse_cause;
      @(posedge ref_clk) disable iff (rst)
      ncoPhaseSyncPulse |-> $past(busRdStb) && $past(syncMaster)
         && $past(busAddr) == rxcfg_pkg::ADDR_TUNING;
   endproperty
   a_pulse_cause: assert property (p_pulse_cause)
      else $error("spurious phase sync pulse");

   property p_tuning_wr;
      @(posedge ref_clk) disable iff (rst)
      busWrStb && busAddr == rxcfg_pkg::ADDR_TUNING
      |=> tuningWord == $past(busWrData[31:0]);
   endproperty
   a_tuning_wr: assert property (p_tuning_wr)
      else $error("tuning word not stored");

   property p_mode_rsvd;
      @(posedge ref_clk) disable iff (rst)
      busRdStb && busAddr == rxcfg_pkg::ADDR_MODE |=> busRdData[35:4] == '0;
   endproperty
   a_mode_rsvd: assert property (p_mode_rsvd)
      else $error("reserved mode bits read nonzero");

   property p_master_oe;
      @(posedge ref_clk) disable iff (rst)
      busWrStb && busAddr == rxcfg_pkg::ADDR_MODE
      |=> syncCicOe_n == !$past(busWrData[rxcfg_pkg::MODE_MASTER_BIT])
          && syncFirOe_n == syncCicOe_n;
   endproperty
   a_master_oe: assert property (p_master_oe)
      else $error("sync enable mismatch");

   property p_s5_rsvd;
      @(posedge ref_clk) disable iff (rst)
      busWrStb && busAddr == rxcfg_pkg::ADDR_S5_SCALE
      |=> state_reg.s5Scale[7:5] == 3'h0
          && stage5AttenuationShift == $past(busWrData[4:0]);
   endproperty
   a_s5_rsvd: assert property (p_s5_rsvd)
      else $error("stage5 scale write wrong");

   property p_rsvd_read;
      @(posedge ref_clk) disable iff (rst)
      busRdStb && (busAddr == rxcfg_pkg::ADDR_RSVD
         || region == rxcfg_pkg::REGION_RSVD) |=> busRdData == '0;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read)
      else $error("reserved location read nonzero");

   property p_coef_read;
      @(posedge ref_clk) disable iff (rst)
      busRdStb && region == rxcfg_pkg::REGION_COEF
      |=> (busRdData >> rxcfg_pkg::COEF_W) == '0;
   endproperty
   a_coef_read: assert property (p_coef_read)
      else $error("coefficient read wider than a word");

   property p_osc_wr;
      @(posedge ref_clk) disable iff (rst)
      busWrStb && busAddr == rxcfg_pkg::ADDR_OSC
      |=> oscBypass == $past(busWrData[rxcfg_pkg::OSC_BYPASS_BIT])
          && phaseDitherEn == $past(busWrData[rxcfg_pkg::OSC_PDITH_BIT])
          && ampDitherEn == $past(busWrData[rxcfg_pkg::OSC_ADITH_BIT]);
   endproperty
   a_osc_wr: assert property (p_osc_wr)
      else $error("oscillator control write wrong");

   property p_in_scale_wr;
      @(posedge ref_clk) disable iff (rst)
      busWrStb && busAddr == rxcfg_pkg::ADDR_IN_SCALE
      |=> stage2AttenuationShift
             == $past(busWrData[rxcfg_pkg::S2_SHIFT_LSB +: 3])
          && exponentDirection == $past(busWrData[rxcfg_pkg::EXP_DIR_BIT])
          && exponentGainOffset
             == $past(busWrData[rxcfg_pkg::EXP_GAIN_LSB +: 3]);
   endproperty
   a_in_scale_wr: assert property (p_in_scale_wr)
      else $error("input scale write wrong");

   property p_complex_mode;
      @(posedge ref_clk) disable iff (rst)
      busWrStb && busAddr == rxcfg_pkg::ADDR_MODE
      && busWrData[rxcfg_pkg::MODE_CPLX_BIT]
      && !busWrData[rxcfg_pkg::MODE_DIV_BIT]
      && !busWrData[rxcfg_pkg::MODE_SOFT_RST_BIT]
      |=> inputMode == rxcfg_pkg::RXCFG_COMPLEX_SINGLE;
   endproperty
   a_complex_mode: assert property (p_complex_mode)
      else $error("complex input mode not decoded");

   property p_tuning_hold;
      @(posedge ref_clk) disable iff (rst)
      !(busWrStb && busAddr == rxcfg_pkg::ADDR_TUNING)
      |=> $stable(tuningWord);
   endproperty
   a_tuning_hold: assert property (p_tuning_hold)
      else $error("tuning word changed without a write");

   property p_taps_wr;
      @(posedge ref_clk) disable iff (rst)
      busWrStb && busAddr == rxcfg_pkg::ADDR_TAPS
      |=> tapCount == $past(wrByte);
   endproperty
   a_taps_wr: assert property (p_taps_wr)
      else $error("tap count not stored");

endmodule

// File: sim/rxcfg_host_model.sv
`timescale 1ns/1ps
// host processor on the control port: one access per call
module rxcfg_host_model (
   input wire logic ref_clk,
   output logic [9:0] busAddr,
   output logic [35:0] busWrData,
   output logic busWrStb,
   output logic busRdStb,
   input wire logic [35:0] busRdData
);
   // quiet bus at time zero
   initial begin
      busAddr = 10'h000;
      busWrData = 36'h0_0000_0000;
      busWrStb = 1'b0;
      busRdStb = 1'b0;
   end

   // write strobe stays up so a following access can come back to back
   task automatic wr(input logic [9:0] a, input logic [35:0] d);
      busAddr <= a;
      busWrData <= d;
      busWrStb <= 1'b1;
      busRdStb <= 1'b0;
      @(posedge ref_clk);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [9:0] a, output logic [35:0] d);
      busAddr <= a;
      busRdStb <= 1'b1;
      busWrStb <= 1'b0;
      @(posedge ref_clk);
      busRdStb <= 1'b0;
      busAddr <= ~a;
      @(posedge ref_clk);
      d = busRdData;
   endtask

   // released lines show the inverse of their last value
   task automatic idle();
      busWrStb <= 1'b0;
      busRdStb <= 1'b0;
      busAddr <= ~busAddr;
      busWrData <= ~busWrData;
      @(posedge ref_clk);
   endtask
endmodule

// File: sim/tb_rxcfg_regbank.sv
`timescale 1ns/1ps
module tb_rxcfg_regbank;
   localparam logic [9:0] TA [15] = '{10'h301, 10'h302, 10'h303, 10'h304,
      10'h305, 10'h306, 10'h307, 10'h308, 10'h309, 10'h30a, 10'h30b,
      10'h30c, 10'h30d, 10'h200, 10'h2ff};
   localparam logic [35:0] TW [15] = '{36'hff, 36'hf_ffff_ffff,
      36'ha5c3_0f01, 36'hf_ffff_ffff, 36'hbe, 36'h0f, 36'hf4, 36'h1f,
      36'hff, 36'h1f, 36'h80, 36'h7f, 36'hff, 36'hff, 36'hff};
   localparam logic [35:0] TE [15] = '{36'h07, 36'hffff_ffff,
      36'ha5c3_0f01, 36'hffff, 36'hb6, 36'h0f, 36'h14, 36'h1f, 36'h0f,
      36'h1f, 36'h80, 36'h7f, 36'h0, 36'h0, 36'h0};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] busAddr;
   logic [35:0] busWrData, busRdData, firSampleRdData, rdv;
   logic [35:0] firSampleWrData = 36'h0;
   logic busWrStb, busRdStb, softResetHeld, syncMaster, oscBypass;
   logic phaseDitherEn, ampDitherEn, expDir, uniqueB, syncPulse;
   logic cicOe_n, firOe_n;
   logic firSampleWe = 1'b0;
   logic [1:0] inputMode;
   logic [31:0] syncMask, tuningWord;
   logic [15:0] phaseWord;
   logic [2:0] s2Shift, expGain, outScale;
   logic [4:0] s5Shift;
   logic [7:0] s2Dec, s5Dec, firDec, coefBase, taps;
   logic [7:0] firCoefAddr = 8'h00;
   logic [7:0] firSampleAddr = 8'h00;
   logic [19:0] firCoefData;
   int errorCnt = 0;
   int checks = 0;

   rxcfg_regbank uut (.ref_clk(ref_clk), .rst(rst), .busAddr(busAddr),
      .busWrData(busWrData), .busWrStb(busWrStb), .busRdStb(busRdStb),
      .busRdData(busRdData), .inputMode(inputMode),
      .softResetHeld(softResetHeld), .syncMaster(syncMaster),
      .oscBypass(oscBypass), .phaseDitherEn(phaseDitherEn),
      .ampDitherEn(ampDitherEn), .syncMask(syncMask),
      .tuningWord(tuningWord), .phaseWord(phaseWord),
      .stage2AttenuationShift(s2Shift), .exponentDirection(expDir),
      .exponentGainOffset(expGain), .stage2DecimationM1(s2Dec),
      .stage5AttenuationShift(s5Shift), .stage5DecimationM1(s5Dec),
      .outputScaleSelect(outScale), .uniqueCoefB(uniqueB),
      .firDecimationM1(firDec), .coefficientBase(coefBase),
      .tapCount(taps), .ncoPhaseSyncPulse(syncPulse),
      .syncCicOe_n(cicOe_n), .syncFirOe_n(firOe_n),
      .firCoefAddr(firCoefAddr), .firCoefData(firCoefData),
      .firSampleAddr(firSampleAddr), .firSampleWe(firSampleWe),
      .firSampleWrData(firSampleWrData), .firSampleRdData(firSampleRdData));

   rxcfg_host_model host (.ref_clk(ref_clk), .busAddr(busAddr),
      .busWrData(busWrData), .busWrStb(busWrStb), .busRdStb(busRdStb),
      .busRdData(busRdData));

   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   // compare, count and report
   task automatic chk(input string what, input logic [127:0] exp,
                      input logic [127:0] got);
      checks++;
      if (got !== exp) begin
         errorCnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rdchk(input logic [9:0] a, input logic [35:0] exp);
      host.rd(a, rdv);
      chk("busRdData", exp, rdv);
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errorCnt);
      if (errorCnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // watchdog against a hung sequence
   initial begin
      repeat (3000) @(posedge ref_clk);
      errorCnt++;
      give_verdict();
   end

   // main sequence
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      chk("mode", 5'h17, {softResetHeld, syncMaster, inputMode,
          cicOe_n});
      rdchk(rxcfg_pkg::ADDR_MODE, 36'h01);
      // input modes 0, 2, 4 decode to real, diversity, complex
      for (int i = 0; i < 3; i++) begin
         host.wr(rxcfg_pkg::ADDR_MODE, 36'(2 * i));
         host.idle();
         chk("inputMode", 128'(i), 128'(inputMode));
      end
      host.wr(rxcfg_pkg::ADDR_MODE, 36'hf8);
      host.idle();
      chk("master", 4'h8, {syncMaster, cicOe_n, firOe_n,
          softResetHeld});
      rdchk(rxcfg_pkg::ADDR_MODE, 36'h08);
      // back to back write and read of the tuning word as master
      host.wr(rxcfg_pkg::ADDR_TUNING, 36'h1234_5678);
      rdchk(rxcfg_pkg::ADDR_TUNING, 36'h1234_5678);
      chk("syncPulse", 1'b1, syncPulse);
      host.wr(rxcfg_pkg::ADDR_MODE, 36'h00);
      rdchk(rxcfg_pkg::ADDR_TUNING, 36'h1234_5678);
      chk("syncPulse", 1'b0, syncPulse);
      // control map except the mode register, plus reserved words, back to back, rates kept within limits
      foreach (TA[k]) host.wr(TA[k], TW[k]);
      host.idle();
      foreach (TA[k]) rdchk(TA[k], TE[k]);
      chk("osc", 3'h7,
          {oscBypass, phaseDitherEn, ampDitherEn});
      chk("words", {32'hffff_ffff, 32'ha5c3_0f01, 16'hffff},
          {syncMask, tuningWord, phaseWord});
      chk("scale", {3'h6, 1'b1, 3'h5, 5'h14, 3'h7, 1'b1},
          {s2Shift, expDir, expGain, s5Shift, outScale,
          uniqueB});
      chk("rates", 40'h0f1f1f807f, {s2Dec, s5Dec, firDec, coefBase,
          taps});
      // coefficient memory at both ends, bus and engine ports
      host.wr(rxcfg_pkg::ADDR_COEF_BASE, 36'hf_fff8_0001);
      host.wr(10'h0ff, 36'h0_0007_fffe);
      rdchk(10'h000, 36'h8_0001);
      rdchk(10'h0ff, 36'h7_fffe);
      firCoefAddr <= 8'hff;
      repeat (2) @(posedge ref_clk);
      chk("firCoefData", 20'h7fffe, firCoefData);
      // sample memory from both sides, kept over a reset
      host.wr(10'h1ff, {18'h2aaaa, 18'h15555});
      host.idle();
      firSampleAddr <= 8'hff;
      repeat (2) @(posedge ref_clk);
      chk("firSampleRdData", {18'h2aaaa, 18'h15555}, firSampleRdData);
      firSampleAddr <= 8'h10;
      firSampleWrData <= {18'h00001, 18'h3ffff};
      firSampleWe <= 1'b1;
      @(posedge ref_clk);
      firSampleWe <= 1'b0;
      rdchk(10'h110, {18'h00001, 18'h3ffff});
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rdchk(10'h1ff, {18'h2aaaa, 18'h15555});
      rdchk(rxcfg_pkg::ADDR_MODE, 36'h01);
      give_verdict();
   end
endmodule
